// >>> common/motor_pwm_pkg.sv
package motor_pwm_pkg;
    localparam int           NUM_CH         = 4;
    localparam int           DUTY_W         = 11;
    localparam logic [7:0]   CTRL_OFFSET    = 8'h00;
    localparam logic [7:0]   PERIOD_OFFSET  = 8'h04;
    localparam logic [7:0]   CFG_BASE       = 8'h10;
    localparam logic [7:0]   DUTY_BASE      = 8'h20;
    localparam logic [7:0]   STATUS_OFFSET  = 8'h30;
    localparam int           COMPACT_BIT    = 0;
    localparam int           FREEWHEEL_BIT  = 7;
    localparam int           SIGN_BIT       = 15;
    localparam logic [10:0]  PERIOD_RESET   = 11'h000;
    localparam logic [1:0]   MODE_HALF_M    = 2'h0;
    localparam logic [1:0]   MODE_HALF_P    = 2'h1;
    localparam logic [1:0]   MODE_FULL      = 2'h2;
    localparam logic [1:0]   MODE_DUAL      = 2'h3;
    localparam logic [1:0]   ALIGN_OFF      = 2'h0;
    localparam logic [1:0]   ALIGN_LEFT     = 2'h1;
    localparam logic [1:0]   ALIGN_RIGHT    = 2'h2;
    localparam logic [1:0]   ALIGN_CENTER   = 2'h3;
    localparam logic [1:0]   RESP_OKAY      = 2'h0;
    localparam logic [1:0]   RESP_SLVERR    = 2'h2;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } axil_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axil_rsp_s;

    typedef struct packed {
        logic [NUM_CH-1:0] p_out;
        logic [NUM_CH-1:0] p_oe;
        logic [NUM_CH-1:0] m_out;
        logic [NUM_CH-1:0] m_oe;
    } pins_s;

    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] align;
    } cfg_s;

    typedef struct packed {
        logic              sign;
        logic [DUTY_W-1:0] value;
    } duty_s;
endpackage

// >>> hdl/hbridge_motor_pwm_duty.sv
// The AXI4-Lite slave port was decided locally.
module hbridge_motor_pwm_duty (
    input  wire logic                     clk,
    input  wire logic                     reset,
    input  wire motor_pwm_pkg::axil_req_s bus_req,
    output      motor_pwm_pkg::axil_rsp_s bus_rsp,
    output      motor_pwm_pkg::pins_s     pins
);

    typedef enum {DRIVE_HALF_M, DRIVE_HALF_P, DRIVE_FULL} drive_e;

    typedef struct packed {
        logic                                    aw_have;
        logic [7:0]                              aw_addr;
        logic                                    w_have;
        logic [31:0]                             w_data;
        logic [3:0]                              w_strb;
        logic                                    bvalid;
        logic [1:0]                              bresp;
        logic                                    rvalid;
        logic [31:0]                             rdata;
        logic [1:0]                              rresp;
        logic                                    compact;
        logic                                    freewheel;
        logic [10:0]                             period;
        logic [10:0]                             period_work;
        motor_pwm_pkg::cfg_s [3:0]               cfg;
        motor_pwm_pkg::cfg_s [3:0]               cfg_work;
        motor_pwm_pkg::duty_s [3:0]              duty;
        motor_pwm_pkg::duty_s [3:0]              duty_work;
        logic [10:0]                             cnt;
        logic [3:0]                              parity;
        logic [1:0]                              odd_written;
        motor_pwm_pkg::pins_s                    pins;
    } state_s;

    state_s     s_q;
    state_s     s_d;
    logic       ovf;
    logic [1:0] dual;
    logic       all_off;

    ////////////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    function automatic logic in_block(input logic [7:0] addr, input logic [7:0] base);
        in_block = (addr[7:4] == base[7:4]);
    endfunction

    function automatic logic mapped(input logic [7:0] addr);
        mapped = (addr == motor_pwm_pkg::CTRL_OFFSET) || (addr == motor_pwm_pkg::PERIOD_OFFSET)
              || (addr == motor_pwm_pkg::STATUS_OFFSET)
              || ((in_block(addr, motor_pwm_pkg::CFG_BASE)
                   || in_block(addr, motor_pwm_pkg::DUTY_BASE)) && addr[1:0] == 2'h0);
    endfunction

    function automatic logic [15:0] duty_view(input motor_pwm_pkg::duty_s d, input logic compact);
        duty_view = compact ? {d.sign, d.value[8:2], 8'h00} : {d.sign, 4'h0, d.value};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Timer and pair status

    always_comb begin
        ovf = (s_q.period_work != 11'h000) && (s_q.cnt >= s_q.period_work - 11'h001);
        all_off = (s_q.period_work == 11'h000);
        // Pair n is channels 2n, 2n+1
        for (int p = 0; p < 2; p++) begin
            dual[p] = (s_q.cfg_work[2*p].align != motor_pwm_pkg::ALIGN_OFF)
                   && (s_q.cfg_work[2*p+1].align != motor_pwm_pkg::ALIGN_OFF)
                   && (s_q.cfg_work[2*p].mode == motor_pwm_pkg::MODE_DUAL)
                   && (s_q.cfg_work[2*p+1].mode == motor_pwm_pkg::MODE_DUAL);
        end
        if (s_q.cfg_work[0].align == motor_pwm_pkg::ALIGN_OFF
            && s_q.cfg_work[1].align == motor_pwm_pkg::ALIGN_OFF
            && s_q.cfg_work[2].align == motor_pwm_pkg::ALIGN_OFF
            && s_q.cfg_work[3].align == motor_pwm_pkg::ALIGN_OFF) begin
            all_off = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic       wr_fire;
        logic [1:0] ch;
        logic [1:0] odd_wr;
        logic       act;
        logic       lvl;
        logic       load;
        drive_e     drv;
        s_d = s_q;
        wr_fire = s_q.aw_have && s_q.w_have && !s_q.bvalid;
        ch = s_q.aw_addr[3:2];
        odd_wr = 2'h0;
        act = 1'b0;
        lvl = 1'b0;
        load = 1'b0;
        drv = DRIVE_HALF_M;

        // Write address and data are taken independently, in either order
        if (bus_req.awvalid && bus_rsp.awready) begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = bus_req.awaddr;
        end
        if (bus_req.wvalid && bus_rsp.wready) begin
            s_d.w_have = 1'b1;
            s_d.w_data = bus_req.wdata;
            s_d.w_strb = bus_req.wstrb;
        end
        if (s_q.bvalid && bus_req.bready) begin
            s_d.bvalid = 1'b0;
        end
        if (wr_fire) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = mapped(s_q.aw_addr) ? motor_pwm_pkg::RESP_OKAY
                                             : motor_pwm_pkg::RESP_SLVERR;
            if (s_q.aw_addr == motor_pwm_pkg::CTRL_OFFSET && s_q.w_strb[0]) begin
                // Only the compact select and freewheel bit change; stored duties stay as they are
                s_d.compact = s_q.w_data[motor_pwm_pkg::COMPACT_BIT];
                s_d.freewheel = s_q.w_data[motor_pwm_pkg::FREEWHEEL_BIT];
            end
            if (s_q.aw_addr == motor_pwm_pkg::PERIOD_OFFSET) begin
                if (s_q.w_strb[0]) begin
                    s_d.period[7:0] = s_q.w_data[7:0];
                end
                if (s_q.w_strb[1]) begin
                    s_d.period[10:8] = s_q.w_data[10:8];
                end
            end
            if (in_block(s_q.aw_addr, motor_pwm_pkg::CFG_BASE) && s_q.aw_addr[1:0] == 2'h0
                && s_q.w_strb[0]) begin
                s_d.cfg[ch].mode = s_q.w_data[7:6];
                s_d.cfg[ch].align = s_q.w_data[5:4];
            end
            if (in_block(s_q.aw_addr, motor_pwm_pkg::DUTY_BASE) && s_q.aw_addr[1:0] == 2'h0) begin
                if (s_q.compact) begin
                    if (s_q.w_strb[1]) begin
                        s_d.duty[ch].sign = s_q.w_data[motor_pwm_pkg::SIGN_BIT];
                        s_d.duty[ch].value = {2'h0, s_q.w_data[14:8], 2'h0};
                    end
                end else begin
                    if (s_q.w_strb[1]) begin
                        s_d.duty[ch].sign = s_q.w_data[motor_pwm_pkg::SIGN_BIT];
                        s_d.duty[ch].value[10:8] = s_q.w_data[10:8];
                    end
                    if (s_q.w_strb[0]) begin
                        s_d.duty[ch].value[7:0] = s_q.w_data[7:0];
                    end
                end
                odd_wr[ch[1]] = ch[0];
            end
        end

        // Reads answer one cycle after the address is taken
        if (s_q.rvalid && bus_req.rready) begin
            s_d.rvalid = 1'b0;
        end
        if (bus_req.arvalid && bus_rsp.arready) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = mapped(bus_req.araddr) ? motor_pwm_pkg::RESP_OKAY
                                               : motor_pwm_pkg::RESP_SLVERR;
            s_d.rdata = 32'h0000_0000;
            if (bus_req.araddr == motor_pwm_pkg::CTRL_OFFSET) begin
                s_d.rdata[motor_pwm_pkg::COMPACT_BIT] = s_q.compact;
                s_d.rdata[motor_pwm_pkg::FREEWHEEL_BIT] = s_q.freewheel;
            end else if (bus_req.araddr == motor_pwm_pkg::PERIOD_OFFSET) begin
                s_d.rdata[10:0] = s_q.period;
            end else if (bus_req.araddr == motor_pwm_pkg::STATUS_OFFSET) begin
                s_d.rdata[10:0] = s_q.cnt;
                s_d.rdata[11] = ovf;
            end else if (mapped(bus_req.araddr)
                         && in_block(bus_req.araddr, motor_pwm_pkg::CFG_BASE)) begin
                s_d.rdata[7:4] = s_q.cfg[bus_req.araddr[3:2]];
            end else if (mapped(bus_req.araddr)) begin
                // Bus copy, not the working copy
                s_d.rdata[15:0] = duty_view(s_q.duty[bus_req.araddr[3:2]], s_q.compact);
            end
        end

        s_d.cnt = (ovf || s_q.period_work == 11'h000) ? 11'h000 : s_q.cnt + 11'h001;
        // Period change, zero included, takes hold at the overflow
        if (ovf || s_q.period_work == 11'h000) begin
            s_d.period_work = s_q.period;
        end
        // Mode and alignment are double buffered too, so a disable also waits
        if (ovf || all_off) begin
            s_d.cfg_work = s_q.cfg;
        end

        for (int p = 0; p < 2; p++) begin
            // Set wins over the clear at overflow
            s_d.odd_written[p] = (s_q.odd_written[p] && !(ovf && dual[p])) || odd_wr[p];
        end

        for (int i = 0; i < 4; i++) begin
            load = (s_q.period == 11'h000) || (s_q.cfg[i].align == motor_pwm_pkg::ALIGN_OFF)
                || (ovf && !dual[i/2]) || (ovf && dual[i/2] && s_q.odd_written[i/2]);
            if (load) begin
                s_d.duty_work[i] = s_q.duty[i];
            end
            if (s_q.cfg_work[i].align == motor_pwm_pkg::ALIGN_OFF) begin
                s_d.parity[i] = 1'b0;
            end else if (ovf) begin
                s_d.parity[i] = !s_q.parity[i];
            end

            unique case (s_q.cfg_work[i].align)
                motor_pwm_pkg::ALIGN_RIGHT: act = (s_q.duty_work[i].value >= s_q.period_work)
                    || (s_q.cnt >= s_q.period_work - s_q.duty_work[i].value);
                motor_pwm_pkg::ALIGN_CENTER: act = s_q.parity[i]
                    ? ((s_q.duty_work[i].value >= s_q.period_work)
                       || (s_q.cnt >= s_q.period_work - s_q.duty_work[i].value))
                    : (s_q.cnt < s_q.duty_work[i].value);
                default: act = (s_q.cnt < s_q.duty_work[i].value);
            endcase

            unique case (s_q.cfg_work[i].mode)
                motor_pwm_pkg::MODE_HALF_M: drv = DRIVE_HALF_M;
                motor_pwm_pkg::MODE_HALF_P: drv = DRIVE_HALF_P;
                // A lone dual channel runs as full bridge
                default: drv = DRIVE_FULL;
            endcase

            s_d.pins.p_oe[i] = 1'b0;
            s_d.pins.m_oe[i] = 1'b0;
            s_d.pins.p_out[i] = 1'b0;
            s_d.pins.m_out[i] = 1'b0;
            if (!all_off && s_q.cfg_work[i].align != motor_pwm_pkg::ALIGN_OFF) begin
                unique case (drv)
                    DRIVE_HALF_M: begin
                        s_d.pins.m_oe[i] = 1'b1;
                        s_d.pins.m_out[i] = !act;
                    end
                    DRIVE_HALF_P: begin
                        s_d.pins.p_oe[i] = 1'b1;
                        s_d.pins.p_out[i] = !act;
                    end
                    DRIVE_FULL: begin
                        lvl = s_q.freewheel ? act : !act;
                        s_d.pins.p_oe[i] = 1'b1;
                        s_d.pins.m_oe[i] = 1'b1;
                        // Sign XOR freewheel picks the pin; other pin static
                        if (s_q.duty_work[i].sign ^ s_q.freewheel) begin
                            s_d.pins.p_out[i] = lvl;
                            s_d.pins.m_out[i] = !s_q.freewheel;
                        end else begin
                            s_d.pins.m_out[i] = lvl;
                            s_d.pins.p_out[i] = !s_q.freewheel;
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register and outputs

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
            s_q.period <= motor_pwm_pkg::PERIOD_RESET;
            s_q.period_work <= motor_pwm_pkg::PERIOD_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        bus_rsp.awready = !s_q.aw_have && !s_q.bvalid;
        bus_rsp.wready = !s_q.w_have && !s_q.bvalid;
        bus_rsp.bvalid = s_q.bvalid;
        bus_rsp.bresp = s_q.bresp;
        bus_rsp.arready = !s_q.rvalid;
        bus_rsp.rvalid = s_q.rvalid;
        bus_rsp.rdata = s_q.rdata;
        bus_rsp.rresp = s_q.rresp;
        pins = s_q.pins;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    a_left_active_low: assert property (@(posedge clk) disable iff (reset)
        !all_off && s_q.cfg_work[0] == {motor_pwm_pkg::MODE_HALF_M, motor_pwm_pkg::ALIGN_LEFT}
        && s_q.cnt < s_q.duty_work[0].value |=> pins.m_oe[0] && !pins.m_out[0])
        else $error("left aligned channel not active during duty count");

    a_zero_duty_static: assert property (@(posedge clk) disable iff (reset)
        !all_off && s_q.cfg_work[0].align != motor_pwm_pkg::ALIGN_OFF
        && s_q.cfg_work[0].mode == motor_pwm_pkg::MODE_FULL && !s_q.freewheel
        && !s_q.duty_work[0].sign && s_q.duty_work[0].value == 11'h000
        |=> pins.m_out[0] && pins.p_out[0])
        else $error("zero duty not static inactive");

    a_full_duty_static: assert property (@(posedge clk) disable iff (reset)
        !all_off && s_q.cfg_work[0].align == motor_pwm_pkg::ALIGN_LEFT
        && s_q.cfg_work[0].mode == motor_pwm_pkg::MODE_FULL && s_q.freewheel
        && s_q.duty_work[0].sign && s_q.duty_work[0].value >= s_q.period_work
        |=> pins.m_out[0] && pins.m_oe[0])
        else $error("duty at period not static active");

    a_compact_low_zero: assert property (@(posedge clk) disable iff (reset)
        bus_req.arvalid && bus_rsp.arready && bus_req.araddr == motor_pwm_pkg::DUTY_BASE
        && s_q.compact |=> s_q.rvalid && s_q.rdata[7:0] == 8'h00)
        else $error("compact duty read low byte not zero");

    a_compact_clears_bits: assert property (@(posedge clk) disable iff (reset)
        s_q.aw_have && s_q.w_have && !s_q.bvalid && s_q.compact && s_q.w_strb[1]
        && s_q.aw_addr == motor_pwm_pkg::DUTY_BASE
        |=> s_q.duty[0].value[10:9] == 2'h0 && s_q.duty[0].value[1:0] == 2'h0)
        else $error("compact write left outer duty bits set");

    a_half_releases_p: assert property (@(posedge clk) disable iff (reset)
        !all_off && s_q.cfg_work[0].align != motor_pwm_pkg::ALIGN_OFF
        && s_q.cfg_work[0].mode == motor_pwm_pkg::MODE_HALF_M
        |=> pins.m_oe[0] && !pins.p_oe[0])
         else $error("half bridge did not release positive pin");

    a_dual_waits_odd: assert property (@(posedge clk) disable iff (reset)
        dual[0] && ovf && !s_q.odd_written[0] && s_q.period != 11'h000
        && s_q.cfg[0].align != motor_pwm_pkg::ALIGN_OFF |=> $stable(s_q.duty_work[0]))
        else $error("dual pair loaded without odd duty write");

    a_period_wraps: assert property (@(posedge clk) disable iff (reset)
        ovf |=> s_q.cnt == 11'h000 ##1 (s_q.period_work < 11'h002 || s_q.cnt == 11'h001))
        else $error("timer counter did not wrap at period");

    a_period_zero_off: assert property (@(posedge clk) disable iff (reset)
        s_q.period_work == 11'h000 |=> pins.p_oe == 4'h0 && pins.m_oe == 4'h0)
        else $error("pins driven with period zero");

    a_reset_released: assert property (@(posedge clk)
        reset |=> pins.p_oe == 4'h0 && pins.m_oe == 4'h0)
        else $error("pins driven after reset");

endmodule

// >>> tb/hbridge_drivers.sv
module hbridge_drivers (
    input  wire logic                 clk,
    input  wire motor_pwm_pkg::pins_s pins,
    output      logic [3:0]           p_line,
    output      logic [3:0]           m_line
);
    timeunit 1ns;
    timeprecision 100ps;
    logic toggle_q = 1'b0;
    // Released lines float: a changing level keeps stale values from passing
    always_ff @(posedge clk) begin
        toggle_q <= ~toggle_q;
    end
    assign p_line = (pins.p_out & pins.p_oe) | ({4{toggle_q}} & ~pins.p_oe);
    assign m_line = (pins.m_out & pins.m_oe) | ({4{toggle_q}} & ~pins.m_oe);
endmodule

// >>> tb/hbridge_motor_pwm_duty_tb.sv
module hbridge_motor_pwm_duty_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic                     clk;
    logic                     reset;
    motor_pwm_pkg::axil_req_s req;
    motor_pwm_pkg::axil_rsp_s rsp;
    motor_pwm_pkg::pins_s     pins;
    logic [3:0]               p_line;
    logic [3:0]               m_line;
    int                       err_total;
    int                       comparisons;
    logic [31:0]              d;
    logic [1:0]               r;
    int                       n;
    int                       dv[4] = '{0, 3, 15, 20};

    hbridge_motor_pwm_duty hbridge_motor_pwm_duty_inst (
        .clk     (clk),
        .reset   (reset),
        .bus_req (req),
        .bus_rsp (rsp),
        .pins    (pins)
    );
    hbridge_drivers hbridge_drivers_inst (
        .clk    (clk),
        .pins   (pins),
        .p_line (p_line),
        .m_line (m_line)
    );

    always #2.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Bounded wait: a hung handshake ends the run as a mismatch
    task automatic limit(input int k);
        if (k >= 50) begin
            err_total++;
            close_out();
        end
    endtask

    // Whole 16-bit writes, both byte lanes
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int k;
        k = 0;
        @(posedge clk);
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= v;
        req.wstrb   <= 4'h3;
        req.bready  <= 1'b1;
        do begin
            @(posedge clk);
            k++;
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (!(rsp.bvalid && !req.awvalid && !req.wvalid) && k < 50);
        r = rsp.bresp;
        req.bready <= 1'b0;
        limit(k);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        int k;
        k = 0;
        @(posedge clk);
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        req.rready  <= 1'b1;
        do begin
            @(posedge clk);
            k++;
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (!(rsp.rvalid && !req.arvalid) && k < 50);
        v = rsp.rdata;
        rs = rsp.rresp;
        req.rready <= 1'b0;
        limit(k);
    endtask

    // Settle two working loads, then count active cycles over one period
    task automatic meas(input int ch, input bit on_p, input bit lvl, output int c);
        c = 0;
        repeat (48) @(posedge clk);
        repeat (16) begin
            @(posedge clk);
            #1;
            if (on_p ? (pins.p_oe[ch] && p_line[ch] === lvl)
                     : (pins.m_oe[ch] && m_line[ch] === lvl)) c++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        reset = 1'b1;
        req = '0;
        err_total = 0;
        comparisons = 0;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        chk(32'(pins), 32'h0);
        rd(motor_pwm_pkg::DUTY_BASE, d, r);
        chk(d, 32'h0);
        wr(motor_pwm_pkg::PERIOD_OFFSET, 32'h10);
        wr(motor_pwm_pkg::CFG_BASE, 32'h10);
        for (int i = 0; i < 4; i++) begin
            wr(motor_pwm_pkg::DUTY_BASE, 32'(dv[i]));
            meas(0, 1'b0, 1'b0, n);
            chk(32'(n), 32'(dv[i] > 16 ? 16 : dv[i]));
        end
        chk({31'h0, pins.p_oe[0]}, 32'h0);
        rd(motor_pwm_pkg::DUTY_BASE, d, r);
        chk(d, 32'h14);
        wr(motor_pwm_pkg::CTRL_OFFSET, 32'h1);
        wr(motor_pwm_pkg::DUTY_BASE, 32'h82FF);
        rd(motor_pwm_pkg::DUTY_BASE, d, r);
        chk(d, 32'h8200);
        meas(0, 1'b0, 1'b0, n);
        chk(32'(n), 32'h8);
        wr(motor_pwm_pkg::CTRL_OFFSET, 32'h0);
        rd(motor_pwm_pkg::DUTY_BASE, d, r);
        chk(d, 32'h8008);
        meas(0, 1'b0, 1'b0, n);
        chk(32'(n), 32'h8);
        // Full bridge, high side freewheel path: zero duty idles both pins high
        wr(motor_pwm_pkg::CFG_BASE, 32'h90);
        wr(motor_pwm_pkg::DUTY_BASE, 32'h0);
        meas(0, 1'b0, 1'b1, n);
        chk(32'(n), 32'h10);
        chk({30'h0, pins.p_oe[0], pins.p_out[0]}, 32'h3);
        // Back to half bridge and let it take hold before the freewheel path moves
        wr(motor_pwm_pkg::CFG_BASE, 32'h10);
        wr(motor_pwm_pkg::DUTY_BASE, 32'h8008);
        repeat (20) @(posedge clk);
        // Freewheel changed while no channel is in a full bridge mode
        wr(motor_pwm_pkg::CTRL_OFFSET, 32'h80);
        wr(motor_pwm_pkg::CFG_BASE, 32'h90);
        meas(0, 1'b0, 1'b1, n);
        chk(32'(n), 32'h8);
        chk({30'h0, pins.p_oe[0], pins.p_out[0]}, 32'h2);
        wr(motor_pwm_pkg::DUTY_BASE, 32'h8014);
        meas(0, 1'b0, 1'b1, n);
        chk(32'(n), 32'h10);
        wr(motor_pwm_pkg::DUTY_BASE, 32'h0008);
        meas(0, 1'b1, 1'b1, n);
        chk(32'(n), 32'h8);
        chk({30'h0, pins.m_oe[0], pins.m_out[0]}, 32'h2);
        // Even duty first, then odd; the pair holds until the odd write
        wr(motor_pwm_pkg::CFG_BASE, 32'hD0);
        wr(motor_pwm_pkg::CFG_BASE + 8'h04, 32'hD0);
        repeat (20) @(posedge clk);
        wr(motor_pwm_pkg::DUTY_BASE, 32'h8004);
        meas(0, 1'b1, 1'b1, n);
        chk(32'(n), 32'h8);
        wr(motor_pwm_pkg::DUTY_BASE + 8'h04, 32'h0);
        meas(0, 1'b0, 1'b1, n);
        chk(32'(n), 32'h4);
        rd(8'h40, d, r);
        chk({30'h0, r}, {30'h0, motor_pwm_pkg::RESP_SLVERR});
        wr(8'h40, 32'h0);
        chk({30'h0, r}, {30'h0, motor_pwm_pkg::RESP_SLVERR});
        wr(motor_pwm_pkg::PERIOD_OFFSET, 32'h0);
        repeat (40) @(posedge clk);
        #1;
        chk(32'(pins), 32'h0);
        close_out();
    end
endmodule
